/* hw/usart_sync_slave_infrared_defs.svh */
// How it works
// - Clock source select cleared makes the port a slave on the external shift clock.
// - Two queued words: first goes to the shift register, second waits, empty flag clear.
// - After the first word leaves, the second loads and the empty flag sets in the same cycle.
// - Empty flag with transmit interrupt enable raises a wake-capable interrupt in Sleep.
// - Single receive enable has no effect in slave mode; continuous receive governs.
// - Continuous receive set before Sleep or Idle still receives and buffers a word.
// - A received word with receive interrupt enable raises a wake-capable interrupt.
// - Clearing continuous receive enable resets the receive error state.
// - Infrared codec works only in 16x baud mode, never in 4x mode.
// - Baud clock pin drives when enabled, asynchronous, clock source set; infrared ignored.
// - Baud clock pin waveform depends only on the divisor, not the 16x/4x mode.
// - With baud clock output active the receive baud generator runs continuously.
// - In Sleep the baud clock pin stops and stays low.
// - Baud clock mode forces the baud clock pin to be an output.
// - Infrared enable in asynchronous 16x mode routes both pins through the codec.
// - The codec stays off in synchronous mode even with infrared enable set.
// - Encoder: a one is all low; a zero is low 7, high 3, low 6 periods.
// - Transmit polarity select sets the infrared transmit idle level only.
// - Each receive falling edge holds decoded data low 16 periods; an edge inside that window adds another 16 after it expires.
// - Decoded stream lags the synchronised infrared input by at most one period.
// - Receive polarity select sets the expected receive idle level only.
// - Synchronous receive samples the data line on the shift clock falling edge.
// - Transmit buffer empty flag clears only by writing new data.
`ifndef USART_SYNC_SLAVE_INFRARED_DEFS_SVH
`define USART_SYNC_SLAVE_INFRARED_DEFS_SVH

`define WORD_WIDTH 8
`define BRG_WIDTH 16
`define FIFO_DEPTH 4
`define BIT_COUNT_WIDTH 4
`define LAST_BIT_INDEX 4'h7
`define PHASE_LAST 4'hf
`define IR_PULSE_FIRST 4'h7
`define IR_PULSE_LAST 4'h9
`define IR_HOLD_LAST 5'h0f
`define SYNC_STAGES 3

`endif

/* hw/usart_pkg.sv */
`include "usart_sync_slave_infrared_defs.svh"

package usart_pkg;

    typedef struct packed {
        logic serial_port_enable;
        logic sync_mode;
        logic clock_source_select;
        logic continuous_receive_enable;
        logic infrared_enable;
        logic transmit_polarity_select;
        logic receive_polarity_select;
        logic baud_16x_mode;
        logic [`BRG_WIDTH-1:0] baud_divisor;
        logic transmit_interrupt_enable;
        logic receive_interrupt_enable;
    } port_config_t;

    typedef struct packed {
        logic sleep_mode;
        logic idle_mode;
    } power_state_t;

    typedef struct packed {
        logic [`SYNC_STAGES-1:0] clock_sync;
        logic [`SYNC_STAGES-1:0] data_sync;
        logic clock_level;
        logic data_level;
        logic [`WORD_WIDTH-1:0] transmit_buffer;
        logic transmit_buffer_full;
        logic [`WORD_WIDTH-1:0] transmit_shift_register;
        logic [`BIT_COUNT_WIDTH-1:0] transmit_bits_left;
        logic [`WORD_WIDTH-1:0] receive_shift_register;
        logic [`BIT_COUNT_WIDTH-1:0] receive_bit_index;
        logic receive_error;
        logic [`BRG_WIDTH-1:0] brg_count;
        logic baud_clock_level;
        logic [3:0] bit_phase;
        logic encode_bit;
        logic transmit_pin_level;
        logic edge_pending;
        logic [4:0] decode_hold;
        logic decoded_level;
    } usart_state_t;

    localparam usart_state_t STATE_RESET = '{
        clock_sync: '0,
        data_sync: '1,
        clock_level: 1'b0,
        data_level: 1'b1,
        transmit_buffer: '0,
        transmit_buffer_full: 1'b0,
        transmit_shift_register: '0,
        transmit_bits_left: '0,
        receive_shift_register: '0,
        receive_bit_index: '0,
        receive_error: 1'b0,
        brg_count: '0,
        baud_clock_level: 1'b0,
        bit_phase: '0,
        encode_bit: 1'b1,
        transmit_pin_level: 1'b1,
        edge_pending: 1'b0,
        decode_hold: '0,
        decoded_level: 1'b1
    };

endpackage

/* hw/usart_sync_slave_infrared.sv */
`timescale 1ns/1ps
`default_nettype none
`include "usart_sync_slave_infrared_defs.svh"

// ----------------------------------------------------------------------------
// Receive word FIFO
// ----------------------------------------------------------------------------

module word_fifo #(
    parameter int WIDTH = `WORD_WIDTH,
    parameter int DEPTH = `FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] FULL_COUNT = CW'(DEPTH);
    localparam logic [AW-1:0] LAST_SLOT = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } fifo_state_t;

    fifo_state_t st_r;
    fifo_state_t st_nxt;
    logic push;
    logic pop;

    function automatic logic [AW-1:0] advance(input logic [AW-1:0] ptr);
        advance = (ptr == LAST_SLOT) ? '0 : AW'(ptr + 1'b1);
    endfunction

    assign in_ready = (st_r.count != FULL_COUNT);
    assign out_valid = (st_r.count != '0);
    assign out_data = st_r.mem[st_r.rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.mem[st_r.wr_ptr] = in_data;
            st_nxt.wr_ptr = advance(st_r.wr_ptr);
        end
        if (pop) begin
            st_nxt.rd_ptr = advance(st_r.rd_ptr);
        end
        if (push && !pop) begin
            st_nxt.count = CW'(st_r.count + 1'b1);
        end else if (pop && !push) begin
            st_nxt.count = CW'(st_r.count - 1'b1);
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule

// ----------------------------------------------------------------------------
// Serial port: synchronous slave and infrared support
// ----------------------------------------------------------------------------

module usart_sync_slave_infrared #(
    parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire usart_pkg::port_config_t cfg,
    input wire usart_pkg::power_state_t power,
    input wire logic tx_write,
    input wire logic [`WORD_WIDTH-1:0] tx_data,
    output logic transmit_buffer_empty_flag,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic [`WORD_WIDTH-1:0] rx_data,
    output logic receive_error,
    output logic tx_interrupt,
    output logic rx_interrupt,
    output logic wake_request,
    input wire logic shift_clock_pin,
    input wire logic receive_pin_in,
    output logic receive_pin_out,
    output logic receive_pin_oe,
    output logic transmit_pin,
    output logic baud_clock_pin,
    output logic baud_clock_oe,
    input wire logic async_tx_serial,
    output logic [3:0] async_bit_phase,
    output logic async_rx_serial,
    output logic baud_tick
);
    usart_pkg::usart_state_t st_r;
    usart_pkg::usart_state_t st_nxt;
    logic slave_mode;
    logic bclk_mode;
    logic ir_active;
    logic brg_run;
    logic tick;
    logic clock_fall;
    logic data_now;
    logic rx_line;
    logic rx_fall;
    logic word_done;
    logic fifo_ready;

    // A change on a pin counts once the second and third stages agree.
    function automatic logic settle(input logic [`SYNC_STAGES-1:0] s, input logic prev);
        settle = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    assign slave_mode = cfg.serial_port_enable && cfg.sync_mode && !cfg.clock_source_select;
    assign bclk_mode = cfg.serial_port_enable && !cfg.sync_mode && cfg.clock_source_select;
    assign ir_active = cfg.serial_port_enable && !cfg.sync_mode && cfg.infrared_enable
                       && cfg.baud_16x_mode;
    assign brg_run = bclk_mode || ir_active;
    // Lowering the divisor below the running count wraps at once instead of running to all ones.
    assign tick = brg_run && (st_r.brg_count >= cfg.baud_divisor);

    // ------------------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ------------------------------------------------------------------------

    // The data pin shares the clock's synchroniser depth so edge and data stay aligned.
    assign clock_fall = st_r.clock_level && !settle(st_r.clock_sync, st_r.clock_level);
    assign data_now = settle(st_r.data_sync, st_r.data_level);
    // Receive polarity normalises the line so idle always reads high.
    assign rx_line = data_now ^ cfg.receive_polarity_select;
    assign rx_fall = ir_active && (st_r.data_level ^ cfg.receive_polarity_select) && !rx_line;
    assign word_done = slave_mode && cfg.continuous_receive_enable && clock_fall
                       && (st_r.receive_bit_index == `LAST_BIT_INDEX);

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------

    always_comb begin
        st_nxt = st_r;
        st_nxt.clock_sync = {st_r.clock_sync[1:0], shift_clock_pin};
        st_nxt.data_sync = {st_r.data_sync[1:0], receive_pin_in};
        st_nxt.clock_level = settle(st_r.clock_sync, st_r.clock_level);
        st_nxt.data_level = data_now;

        // Transmit buffer and shift register.
        if (tx_write && !st_r.transmit_buffer_full) begin
            st_nxt.transmit_buffer = tx_data;
            st_nxt.transmit_buffer_full = 1'b1;
        end
        if (slave_mode && !cfg.continuous_receive_enable && clock_fall
            && st_r.transmit_bits_left != '0) begin
            st_nxt.transmit_shift_register = st_r.transmit_shift_register >> 1;
            st_nxt.transmit_bits_left = st_r.transmit_bits_left - 1'b1;
        end
        // The waiting word moves only once the shift register is empty.
        if (st_r.transmit_buffer_full && st_r.transmit_bits_left == '0) begin
            st_nxt.transmit_shift_register = st_r.transmit_buffer;
            st_nxt.transmit_bits_left = `LAST_BIT_INDEX + 1'b1;
            st_nxt.transmit_buffer_full = 1'b0;
        end

        // Slave reception runs in any power state; single receive enable is not consulted.
        if (!cfg.continuous_receive_enable || !slave_mode) begin
            st_nxt.receive_bit_index = '0;
            if (!cfg.continuous_receive_enable) begin
                st_nxt.receive_error = 1'b0;
            end
        end else if (clock_fall) begin
            st_nxt.receive_shift_register = {data_now, st_r.receive_shift_register[`WORD_WIDTH-1:1]};
            st_nxt.receive_bit_index = word_done ? '0 : st_r.receive_bit_index + 1'b1;
            if (word_done && !fifo_ready) begin
                st_nxt.receive_error = 1'b1;
            end
        end

        // Baud rate generator; its period depends on the divisor alone.
        if (!brg_run) begin
            st_nxt.brg_count = '0;
        end else if (tick) begin
            st_nxt.brg_count = '0;
        end else begin
            st_nxt.brg_count = st_r.brg_count + 1'b1;
        end
        st_nxt.baud_clock_level = bclk_mode && !power.sleep_mode
                                  && (st_nxt.brg_count <= (cfg.baud_divisor >> 1));

        // Infrared encoder.
        if (!ir_active) begin
            st_nxt.bit_phase = '0;
            st_nxt.encode_bit = 1'b1;
            st_nxt.transmit_pin_level = async_tx_serial;
        end else begin
            if (tick) begin
                st_nxt.bit_phase = st_r.bit_phase + 1'b1;
                if (st_r.bit_phase == `PHASE_LAST) begin
                    st_nxt.encode_bit = async_tx_serial;
                end
            end
            st_nxt.transmit_pin_level = cfg.transmit_polarity_select
                ^ (!st_nxt.encode_bit && st_nxt.bit_phase >= `IR_PULSE_FIRST
                   && st_nxt.bit_phase <= `IR_PULSE_LAST);
        end

        // Infrared decoder; an edge seen inside a low window is kept until that window expires.
        if (!ir_active) begin
            st_nxt.edge_pending = 1'b0;
            st_nxt.decode_hold = '0;
            st_nxt.decoded_level = 1'b1;
        end else begin
            st_nxt.edge_pending = rx_fall || (st_r.edge_pending && !(tick && st_r.decode_hold == '0));
            if (tick) begin
                if (st_r.decode_hold != '0) begin
                    st_nxt.decode_hold = st_r.decode_hold - 1'b1;
                end else if (st_r.edge_pending) begin
                    st_nxt.decoded_level = 1'b0;
                    st_nxt.decode_hold = `IR_HOLD_LAST;
                end else begin
                    st_nxt.decoded_level = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            st_r <= usart_pkg::STATE_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Receive buffer
    // ------------------------------------------------------------------------

    // A full buffer refuses the word and the overrun sets the receive error.
    word_fifo #(
        .WIDTH(`WORD_WIDTH),
        .DEPTH(FIFO_DEPTH)
    ) receive_buffer (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .in_valid(word_done),
        .in_ready(fifo_ready),
        .in_data({data_now, st_r.receive_shift_register[`WORD_WIDTH-1:1]}),
        .out_valid(rx_valid),
        .out_ready(rx_ready),
        .out_data(rx_data)
    );

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------

    assign transmit_buffer_empty_flag = !st_r.transmit_buffer_full;
    assign receive_error = st_r.receive_error;
    assign tx_interrupt = transmit_buffer_empty_flag && cfg.transmit_interrupt_enable;
    assign rx_interrupt = rx_valid && cfg.receive_interrupt_enable;
    assign wake_request = (power.sleep_mode || power.idle_mode) && (tx_interrupt || rx_interrupt);
    assign receive_pin_oe = slave_mode && !cfg.continuous_receive_enable && st_r.transmit_bits_left != '0;
    assign receive_pin_out = st_r.transmit_shift_register[0];
    assign transmit_pin = st_r.transmit_pin_level;
    assign baud_clock_pin = st_r.baud_clock_level;
    assign baud_clock_oe = bclk_mode;
    assign async_bit_phase = st_r.bit_phase;
    assign async_rx_serial = ir_active ? st_r.decoded_level : rx_line;
    assign baud_tick = tick;
endmodule

`default_nettype wire

/* bench/usart_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Checker on the serial port's top ports.
// ----------------------------------------
module usart_monitor (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire usart_pkg::port_config_t cfg,
    input wire usart_pkg::power_state_t power,
    input wire logic tx_write,
    input wire logic transmit_buffer_empty_flag,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic [7:0] rx_data,
    input wire logic receive_error,
    input wire logic wake_request,
    input wire logic baud_clock_pin,
    input wire logic baud_clock_oe
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    wire logic bclk_mode = cfg.serial_port_enable & ~cfg.sync_mode & cfg.clock_source_select;
    wire logic tx_cause = power.sleep_mode & transmit_buffer_empty_flag & cfg.transmit_interrupt_enable;
    wire logic rx_cause = (power.sleep_mode | power.idle_mode) & rx_valid & cfg.receive_interrupt_enable;
    sequence s_write;
        tx_write && transmit_buffer_empty_flag;
    endsequence
    a_write_clears: assert property (s_write |=> !transmit_buffer_empty_flag)
        else $error("empty flag stayed high after a write");
    a_flag_cause: assert property ($fell(transmit_buffer_empty_flag) |-> $past(tx_write))
        else $error("empty flag fell without a write");
    a_tx_wake: assert property (tx_cause |-> wake_request)
        else $error("no wake on transmit buffer empty");
    a_rx_wake: assert property (rx_cause |-> wake_request)
        else $error("no wake on received word");
    a_error_clear: assert property ((!cfg.continuous_receive_enable) [*2] |-> !receive_error)
        else $error("receive error kept with receive disabled");
    a_bclk_sleep: assert property (power.sleep_mode [*2] |-> !baud_clock_pin)
        else $error("baud clock high in sleep");
    a_bclk_forced: assert property (bclk_mode [*2] |-> baud_clock_oe)
        else $error("baud clock pin not driven");
    a_rx_hold: assert property (rx_valid && !rx_ready |=> rx_valid && $stable(rx_data))
        else $error("received word lost before it was taken");
endmodule
bind usart_sync_slave_infrared usart_monitor mon (.core_clk, .reset_n, .cfg, .power, .tx_write,
    .transmit_buffer_empty_flag, .rx_valid, .rx_ready, .rx_data, .receive_error, .wake_request,
    .baud_clock_pin, .baud_clock_oe);
`default_nettype wire

/* bench/sync_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// External master on shift clock and data.
// ----------------------------------------
module sync_master_model (
    input wire logic core_clk,
    input wire logic line,
    output logic shift_clock,
    output logic drive
);
    initial begin
        shift_clock = 1'b1;
        drive = 1'b1;
    end
    // The clock idles high and stands still between words; the released line shows the inverse bit.
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 0; i < 8; i++) begin
            drive <= tx[i];
            repeat (6) @(posedge core_clk);
            rx[i] = line;
            shift_clock <= 1'b0;
            repeat (6) @(posedge core_clk);
            shift_clock <= 1'b1;
        end
        drive <= ~tx[7];
    endtask
endmodule
`default_nettype wire

/* bench/usart_sync_slave_infrared_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Self-checking bench for the serial port.
// ----------------------------------------
module usart_sync_slave_infrared_tb_top;
    logic core_clk, prev_bclk, shift_clock, drive;
    logic reset_n = 1'b0, tx_write = 1'b0, rx_ready = 1'b0, async_tx_serial = 1'b1, use_ir = 1'b0, ir_level = 1'b1;
    logic [7:0] tx_data = 8'h00, rx_data, got;
    logic [15:0] e;
    usart_pkg::port_config_t cfg = '0;
    usart_pkg::power_state_t power = '0;
    logic empty_flag, rx_valid, receive_error, wake, pin_out, pin_oe, transmit_pin, baud_clock_pin, baud_clock_oe;
    logic async_rx_serial, baud_tick, tx_int, rx_int;
    logic [3:0] phase;
    wire logic line = pin_oe ? pin_out : drive;
    wire logic pin_in = use_ir ? ir_level : line;
    int error_cnt = 0, checked = 0, cyc = 0, c;
    usart_sync_slave_infrared dut (.core_clk, .reset_n, .cfg, .power, .tx_write, .tx_data, .rx_valid, .rx_ready,
        .transmit_buffer_empty_flag(empty_flag), .rx_data, .receive_error, .tx_interrupt(tx_int), .rx_interrupt(rx_int),
        .wake_request(wake), .shift_clock_pin(shift_clock), .receive_pin_in(pin_in), .receive_pin_out(pin_out),
        .receive_pin_oe(pin_oe), .transmit_pin, .baud_clock_pin, .baud_clock_oe, .async_tx_serial,
        .async_bit_phase(phase), .async_rx_serial, .baud_tick);
    sync_master_model m (.core_clk, .line, .shift_clock, .drive);
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        prev_bclk <= baud_clock_pin;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            results();
        end
    end
    task automatic check(input logic [15:0] g, input logic [15:0] x);
        checked++;
        if (g !== x) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] d);
        @(posedge core_clk);
        tx_write <= 1'b1;
        tx_data <= d;
        @(posedge core_clk);
        tx_write <= 1'b0;
    endtask
    // Counts cycles with transmit high (0), decoded receive low (1), a baud clock rise (2),
    // a baud tick (3) or the encoder phase at its last value (4).
    task automatic count(input int n, input int sel);
        c = 0;
        repeat (n) begin
            @(posedge core_clk);
            c += int'(sel == 0 ? transmit_pin : sel == 1 ? !async_rx_serial : sel == 2 ? baud_clock_pin & !prev_bclk
                      : sel == 3 ? baud_tick : phase == 4'hf);
        end
    endtask
    task automatic results();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        step(16);
        reset_n <= 1'b1;
        step(1);
        check(16'({empty_flag, rx_valid, receive_error}), 16'h0004);
        cfg.serial_port_enable <= 1'b1;
        cfg.sync_mode <= 1'b1;
        cfg.continuous_receive_enable <= 1'b1;
        cfg.receive_interrupt_enable <= 1'b1;
        power.idle_mode <= 1'b1;
        // Five words into a four-deep buffer: the last one overruns.
        for (int k = 0; k < 5; k++) begin
            m.xfer(8'ha5 + 8'(k), got);
            step(2);
            if (k == 0) check(16'({rx_valid, wake, rx_int, rx_data}), 16'h07a5);
        end
        check(16'(receive_error), 16'h0001);
        cfg.continuous_receive_enable <= 1'b0;
        step(3);
        check(16'(receive_error), 16'h0000);
        for (int k = 0; k < 4; k++) begin
            check(16'({rx_valid, rx_data}), 16'h01a5 + 16'(k));
            rx_ready <= 1'b1;
            step(1);
            rx_ready <= 1'b0;
            step(2);
        end
        check(16'(rx_valid), 16'h0000);
        cfg.transmit_interrupt_enable <= 1'b1;
        cfg.receive_interrupt_enable <= 1'b0;
        power.idle_mode <= 1'b0;
        wr(8'h96);
        step(3);
        check(16'(empty_flag), 16'h0001);
        wr(8'h3c);
        power.sleep_mode <= 1'b1;
        step(4);
        check(16'({empty_flag, wake, tx_int}), 16'h0000);
        m.xfer(8'h00, got);
        check(16'(got), 16'h0096);
        step(2);
        check(16'({empty_flag, wake, tx_int}), 16'h0007);
        m.xfer(8'h00, got);
        check(16'(got), 16'h003c);
        cfg.sync_mode <= 1'b0;
        cfg.clock_source_select <= 1'b1;
        cfg.baud_divisor <= 16'h0003;
        count(20, 2);
        check(16'(c), 16'h0000);
        power.sleep_mode <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            cfg.baud_16x_mode <= k[0];
            step(10);
            count(40, 2);
            check(16'({baud_clock_oe, 8'(c)}), 16'h010a);
            count(40, 3);
            check(16'(c), 16'h000a);
        end
        cfg.clock_source_select <= 1'b0;
        cfg.infrared_enable <= 1'b1;
        cfg.baud_divisor <= 16'h0000;
        for (int k = 0; k < 8; k++) begin
            cfg.baud_16x_mode <= k[2];
            cfg.transmit_polarity_select <= k[1];
            async_tx_serial <= k[0];
            step(40);
            count(64, 0);
            e = k[0] ? 16'h0040 : 16'h0000;
            if (k[2]) e = k[0] ? (k[1] ? 16'h0040 : 16'h0000) : (k[1] ? 16'h0034 : 16'h000c);
            check(16'(c), e);
            count(64, 4);
            check(16'(c), k[2] ? 16'h0004 : 16'h0000);
        end
        cfg.baud_16x_mode <= 1'b1;
        use_ir <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            cfg.receive_polarity_select <= k[0];
            ir_level <= ~k[0];
            step(30);
            fork
                count(60, 1);
                repeat (k[1] + 1) begin
                    ir_level <= k[0];
                    step(3);
                    ir_level <= ~k[0];
                    step(7);
                end
            join
            check(16'(c), k[1] ? 16'h0020 : 16'h0010);
        end
        results();
    end
endmodule
`default_nettype wire
